// *** logic/host_port_defines.svh ***
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL      5'h00
`define OFS_ADDR      5'h04
`define OFS_WDATA     5'h08
`define OFS_RDATA     5'h0c
`define OFS_STATUS    5'h10
`define OFS_PINMODE   5'h14
`define OFS_GPIOMODE  5'h18

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CTRL_GO       0
`define CTRL_READ     1
`define CTRL_BYTE     2
`define CTRL_ENDIAN   3
`define CTRL_DEVRST   4
`define CTRL_RST      5'h10

// ------------------------------------------------------------
// status fields, write one to clear the sticky ones
// ------------------------------------------------------------
`define ST_BUSY       0
`define ST_DONE       1
`define ST_TIMEOUT    2
`define ST_WINERR     3
`define ST_CFGERR     4
`define ST_INWIN      5
`define ST_ROUTEOK    6
`define ST_ENDIAN     7
`define ST_DEVRST     8

// ------------------------------------------------------------
// device window in the host physical map
// ------------------------------------------------------------
`define WIN_BASE      32'h133e_0000
`define WIN_MASK      32'hfffe_0000

// ------------------------------------------------------------
// host pin-mode registers
// ------------------------------------------------------------
`define PINMODE_HOST_ADDR  32'h0b00_032e
`define GPIOMODE_HOST_ADDR 32'h0b00_0304
`define PM_EXT_EN     7
`define PM_WIN_HI     1
`define PM_WIN_LO     0
`define PM_WIN_128K   2'b01
`define GM_UBE_HI     9
`define GM_UBE_LO     8
`define GM_UBE_ROUTE  2'b11
`define GM_RDY_HI     5
`define GM_RDY_LO     4
`define GM_RDY_ROUTE  2'b01
`define MODE_RST      16'h0000

// ------------------------------------------------------------
// straps and timing
// ------------------------------------------------------------
`define STRAP_HIGH      1'b1
`define CLK_NS          40
`define BCLK_HALF_NS    160
`define STROBE_MIN_CYC  4
`define TIMEOUT_CYC     4096

`endif

// *** logic/host_port_pkg.sv ***
`default_nettype none

package host_port_pkg;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_SETUP   = 3'b001,
		ST_STROBE  = 3'b010,
		ST_WAIT    = 3'b011,
		ST_RELEASE = 3'b100
	} cyc_state_e;

endpackage

`default_nettype wire

// *** logic/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	// pins in, synchronised out
	input  wire logic [WIDTH-1:0] d,
	output var  logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;

	// first stage read only by the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			q       <= '0;
		end else if (ce) begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule // pin_sync

`default_nettype wire

// *** logic/host_port_ctrl.sv ***
// Contract
// RULE1: device occupies 128 KB window at 133E0000h
// RULE2: select low only for in-window accesses
// RULE3: strobe held low; device wait stretches cycle
// RULE4: upper byte enable low 16-bit, high 8-bit
// RULE5: device presents 16-bit generic host port
// RULE6: device syncs transfers to bus clock
// RULE7: address and data lines connect directly
// RULE8: select decoded from high address lines
// RULE9: straps latched at reset rise; endian select
// RULE10: generic mode when all bus straps high
// RULE11: upper strobe is byte enable both directions
// RULE12: host drives lower write strobe for writes
// RULE13: host drives read strobe low for reads
// RULE14: host waits until device wait releases; the code gives up after TIMEOUT_CYC cycles and flags a timeout
// RULE15: active-low wait inverted for host use
// RULE16: bus status and direction pins tied high
// RULE17: control pins asynchronous to bus clock
// RULE18: pin-mode bit 7 enables external select
// RULE19: pin-mode bits 1:0 equal 01b window
// RULE20: gpio-mode bits 9:8 equal 11b byte enable
// RULE21: gpio-mode bits 5:4 equal 01b ready
// RULE22: read data held until read strobe released
`timescale 1ns/1ns
`default_nettype none
`include "host_port_defines.svh"

module host_port_ctrl #(
	parameter int HALF_CYC    = `BCLK_HALF_NS / `CLK_NS,
	parameter int STROBE_MIN  = `STROBE_MIN_CYC,
	parameter int TIMEOUT_CYC = `TIMEOUT_CYC
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	// device bus pins
	output var  logic        host_side_clock,
	output var  logic [16:0] ctrl_addr_in,
	input  wire logic [15:0] ctrl_data_bus_i,
	output var  logic [15:0] ctrl_data_bus_o,
	output var  logic        ctrl_data_bus_oe_n,
	output var  logic        host_display_select_n,
	output var  logic        host_upper_byte_enable_n,
	output var  logic        lower_write_strobe_n,
	output var  logic        read_strobe_n,
	input  wire logic        device_wait_n,
	// device reset and straps
	output var  logic        device_reset_n,
	output var  logic        bus_select_strap0,
	output var  logic        bus_select_strap1,
	output var  logic        bus_select_strap2,
	output var  logic        bus_status_strap,
	output var  logic        rw_dir_tie,
	output var  logic        endian_strap
);

	localparam int CW = $clog2(TIMEOUT_CYC + 1);
	localparam int DW = $clog2(HALF_CYC + 1);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic in_window(input logic [31:0] a);
		in_window = (a & `WIN_MASK) == `WIN_BASE; // RULE1 RULE8
	endfunction

	function automatic logic route_ok(input logic [15:0] pm, input logic [15:0] gm);
		route_ok = pm[`PM_EXT_EN] // RULE18
			&& (pm[`PM_WIN_HI:`PM_WIN_LO] == `PM_WIN_128K) // RULE19
			&& (gm[`GM_UBE_HI:`GM_UBE_LO] == `GM_UBE_ROUTE) // RULE20
			&& (gm[`GM_RDY_HI:`GM_RDY_LO] == `GM_RDY_ROUTE); // RULE21
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [16:0] pin_q;

	// wait and data are asynchronous to clk
	pin_sync #(.WIDTH(17)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.d      ({device_wait_n, ctrl_data_bus_i}),
		.q      (pin_q)
	); // RULE17

	logic wait_ready;
	assign wait_ready = pin_q[16]; // RULE15

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	host_port_pkg::cyc_state_e state_ff;
	logic [4:0]  ctrl_ff;
	logic [31:0] addr_ff;
	logic [15:0] wdata_ff;
	logic [15:0] rdata_ff;
	logic [15:0] pinmode_ff;
	logic [15:0] gpiomode_ff;
	logic        done_ff;
	logic        timeout_ff;
	logic        winerr_ff;
	logic        cfgerr_ff;
	logic        op_read_ff;
	logic [CW-1:0] cnt_ff;
	logic [DW-1:0] div_ff;
	logic [31:0] nxt_readdata;

	logic wr_take;
	logic go;
	logic start;
	logic busy;
	logic finish;
	logic to_hit;
	logic bclk_rise;
	logic clr_done;
	logic clr_timeout;
	logic clr_winerr;
	logic clr_cfgerr;

	// a write lands at the edge where waitrequest is seen low
	assign wr_take = avs_write && !avs_waitrequest;
	assign go      = wr_take && (avs_address == `OFS_CTRL) && avs_writedata[`CTRL_GO];
	assign busy    = state_ff != host_port_pkg::ST_IDLE;
	assign start   = go && !busy && !ctrl_ff[`CTRL_DEVRST]
		&& route_ok(pinmode_ff, gpiomode_ff) && in_window(addr_ff);
	assign to_hit  = (state_ff == host_port_pkg::ST_WAIT) && !wait_ready
		&& (cnt_ff == CW'(TIMEOUT_CYC - 1));
	assign finish  = (state_ff == host_port_pkg::ST_RELEASE) && bclk_rise;

	assign clr_done    = wr_take && (avs_address == `OFS_STATUS) && avs_writedata[`ST_DONE];
	assign clr_timeout = wr_take && (avs_address == `OFS_STATUS) && avs_writedata[`ST_TIMEOUT];
	assign clr_winerr  = wr_take && (avs_address == `OFS_STATUS) && avs_writedata[`ST_WINERR];
	assign clr_cfgerr  = wr_take && (avs_address == `OFS_STATUS) && avs_writedata[`ST_CFGERR];

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	always_comb begin
		nxt_readdata = '0;
		unique case (avs_address)
			`OFS_CTRL:     nxt_readdata[4:0]  = ctrl_ff;
			`OFS_ADDR:     nxt_readdata       = addr_ff;
			`OFS_WDATA:    nxt_readdata[15:0] = wdata_ff;
			`OFS_RDATA:    nxt_readdata[15:0] = rdata_ff;
			`OFS_STATUS: begin
				nxt_readdata[`ST_BUSY]    = busy;
				nxt_readdata[`ST_DONE]    = done_ff;
				nxt_readdata[`ST_TIMEOUT] = timeout_ff;
				nxt_readdata[`ST_WINERR]  = winerr_ff;
				nxt_readdata[`ST_CFGERR]  = cfgerr_ff;
				nxt_readdata[`ST_INWIN]   = in_window(addr_ff);
				nxt_readdata[`ST_ROUTEOK] = route_ok(pinmode_ff, gpiomode_ff);
				nxt_readdata[`ST_ENDIAN]  = endian_strap;
				nxt_readdata[`ST_DEVRST]  = !device_reset_n;
			end
			`OFS_PINMODE:  nxt_readdata[15:0] = pinmode_ff;
			`OFS_GPIOMODE: nxt_readdata[15:0] = gpiomode_ff;
			default:       nxt_readdata       = '0;
		endcase
	end

	// one wait cycle, then a single low cycle of waitrequest
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
		end else if (ce) begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= nxt_readdata;
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff     <= `CTRL_RST;
			addr_ff     <= '0;
			wdata_ff    <= '0;
			pinmode_ff  <= `MODE_RST;
			gpiomode_ff <= `MODE_RST;
		end else if (ce && wr_take) begin
			unique case (avs_address)
				`OFS_CTRL:     ctrl_ff     <= {avs_writedata[4:1], 1'b0};
				`OFS_ADDR:     addr_ff     <= avs_writedata;
				`OFS_WDATA:    wdata_ff    <= avs_writedata[15:0];
				`OFS_PINMODE:  pinmode_ff  <= avs_writedata[15:0];
				`OFS_GPIOMODE: gpiomode_ff <= avs_writedata[15:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// sticky flags, a set beats a clear in the same cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_ff    <= 1'b0;
			timeout_ff <= 1'b0;
			winerr_ff  <= 1'b0;
			cfgerr_ff  <= 1'b0;
		end else if (ce) begin
			done_ff    <= finish || (done_ff && !clr_done);
			timeout_ff <= to_hit || (timeout_ff && !clr_timeout);
			winerr_ff  <= (go && !in_window(addr_ff)) || (winerr_ff && !clr_winerr); // RULE2
			cfgerr_ff  <= (go && (busy || ctrl_ff[`CTRL_DEVRST]
				|| !route_ok(pinmode_ff, gpiomode_ff))) || (cfgerr_ff && !clr_cfgerr);
		end
	end

	// ------------------------------------------------------------
	// bus clock divider
	// ------------------------------------------------------------
	// host makes the device bus clock; cycles align to its rise
	assign bclk_rise = (div_ff == DW'(HALF_CYC - 1)) && !host_side_clock;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_ff          <= '0;
			host_side_clock <= 1'b0;
		end else if (ce) begin
			if (div_ff == DW'(HALF_CYC - 1)) begin
				div_ff          <= '0;
				host_side_clock <= !host_side_clock; // RULE6
			end else begin
				div_ff <= div_ff + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// device reset and straps
	// ------------------------------------------------------------
	// straps only move while reset is held, so they are stable at its rise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			device_reset_n    <= 1'b0;
			endian_strap      <= 1'b0;
			bus_select_strap0 <= `STRAP_HIGH;
			bus_select_strap1 <= `STRAP_HIGH;
			bus_select_strap2 <= `STRAP_HIGH;
			bus_status_strap  <= `STRAP_HIGH;
			rw_dir_tie        <= `STRAP_HIGH;
		end else if (ce) begin
			device_reset_n <= !ctrl_ff[`CTRL_DEVRST];
			// frozen once reset release is queued, so the strap never moves with it
			if (!device_reset_n && ctrl_ff[`CTRL_DEVRST]) begin
				endian_strap <= ctrl_ff[`CTRL_ENDIAN]; // RULE9
			end
			bus_select_strap0 <= `STRAP_HIGH; // RULE10
			bus_select_strap1 <= `STRAP_HIGH;
			bus_select_strap2 <= `STRAP_HIGH;
			bus_status_strap  <= `STRAP_HIGH; // RULE16
			rw_dir_tie        <= `STRAP_HIGH;
		end
	end

	// ------------------------------------------------------------
	// device cycle sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff                 <= host_port_pkg::ST_IDLE;
			cnt_ff                   <= '0;
			op_read_ff               <= 1'b0;
			rdata_ff                 <= '0;
			ctrl_addr_in             <= '0;
			ctrl_data_bus_o          <= '0;
			ctrl_data_bus_oe_n       <= 1'b1;
			host_display_select_n    <= 1'b1;
			host_upper_byte_enable_n <= 1'b1;
			lower_write_strobe_n     <= 1'b1;
			read_strobe_n            <= 1'b1;
		end else if (ce) begin
			unique case (state_ff)
				host_port_pkg::ST_IDLE: begin
					if (start) begin
						op_read_ff               <= avs_writedata[`CTRL_READ];
						ctrl_addr_in             <= addr_ff[16:0]; // RULE7
						ctrl_data_bus_o          <= wdata_ff; // RULE5
						ctrl_data_bus_oe_n       <= avs_writedata[`CTRL_READ];
						host_display_select_n    <= 1'b0; // RULE2
						host_upper_byte_enable_n <= avs_writedata[`CTRL_BYTE]; // RULE4 RULE11
						state_ff                 <= host_port_pkg::ST_SETUP;
					end
				end
				host_port_pkg::ST_SETUP: begin
					if (bclk_rise) begin
						read_strobe_n        <= !op_read_ff; // RULE13
						lower_write_strobe_n <= op_read_ff; // RULE12
						cnt_ff               <= '0;
						state_ff             <= host_port_pkg::ST_STROBE;
					end
				end
				host_port_pkg::ST_STROBE: begin
					// covers sync delay before the device can pull wait low
					if (cnt_ff == CW'(STROBE_MIN - 1)) begin
						cnt_ff   <= '0;
						state_ff <= host_port_pkg::ST_WAIT;
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
				host_port_pkg::ST_WAIT: begin
					if (wait_ready || to_hit) begin // RULE3 RULE14
						if (op_read_ff && wait_ready) begin
							rdata_ff <= pin_q[15:0]; // RULE22
						end
						read_strobe_n        <= 1'b1;
						lower_write_strobe_n <= 1'b1;
						state_ff             <= host_port_pkg::ST_RELEASE;
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
				host_port_pkg::ST_RELEASE: begin
					if (bclk_rise) begin
						host_display_select_n    <= 1'b1;
						host_upper_byte_enable_n <= 1'b1;
						ctrl_data_bus_oe_n       <= 1'b1;
						state_ff                 <= host_port_pkg::ST_IDLE;
					end
				end
				default: state_ff <= host_port_pkg::ST_IDLE;
			endcase
		end
	end

endmodule // host_port_ctrl

`default_nettype wire

// *** dv/host_port_ctrl_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none

module host_port_ctrl_checker #(
	parameter int HALF_CYC    = 4,
	parameter int STROBE_MIN  = 4,
	parameter int TIMEOUT_CYC = 4096
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// device bus pins
	input wire logic        host_side_clock,
	input wire logic [16:0] ctrl_addr_in,
	input wire logic        ctrl_data_bus_oe_n,
	input wire logic        host_display_select_n,
	input wire logic        host_upper_byte_enable_n,
	input wire logic        lower_write_strobe_n,
	input wire logic        read_strobe_n,
	input wire logic        device_wait_n,
	// device reset and straps
	input wire logic        device_reset_n,
	input wire logic        bus_select_strap0,
	input wire logic        bus_select_strap1,
	input wire logic        bus_select_strap2,
	input wire logic        bus_status_strap,
	input wire logic        rw_dir_tie,
	input wire logic        endian_strap
);
	logic strobe;
	assign strobe = !read_strobe_n || !lower_write_strobe_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_straps_generic:
	assert property (bus_select_strap0 && bus_select_strap1 && bus_select_strap2
		&& bus_status_strap && rw_dir_tie) else $error("strap pin not high");
	a_endian_frozen:
	assert property ($changed(endian_strap) |-> !device_reset_n)
		else $error("endian strap moved outside device reset");
	a_strobe_selected:
	assert property (strobe |-> !host_display_select_n) else $error("strobe without select");
	a_strobe_exclusive:
	assert property (!(!read_strobe_n && !lower_write_strobe_n)) else $error("both strobes low");
	a_write_drives:
	assert property (!lower_write_strobe_n |-> !ctrl_data_bus_oe_n) else $error("write undriven");
	a_read_floats:
	assert property (!read_strobe_n |-> ctrl_data_bus_oe_n) else $error("read with host driving");
	a_wait_holds:
	assert property ((strobe && !device_wait_n)[*3] |=> strobe)
		else $error("strobe released while device waits");
	a_write_width:
	assert property ($fell(lower_write_strobe_n) |-> !lower_write_strobe_n[*4])
		else $error("write strobe too short");
	a_read_width:
	assert property ($fell(read_strobe_n) |-> !read_strobe_n[*4]) else $error("read strobe short");
	a_cycle_stable:
	assert property (!host_display_select_n && !$past(host_display_select_n)
		|-> $stable(ctrl_addr_in) && $stable(host_upper_byte_enable_n))
		else $error("address or byte enable moved in cycle");
	a_bus_clock:
	assert property ($rose(host_side_clock) |-> host_side_clock[*4] ##1 !host_side_clock)
		else $error("bus clock half period wrong");
	a_idle_in_reset:
	assert property (!device_reset_n |-> host_display_select_n) else $error("access in reset");

	cover property ($rose(lower_write_strobe_n));
	cover property ($rose(read_strobe_n));
	cover property (strobe && !device_wait_n);
	cover property (!lower_write_strobe_n && host_upper_byte_enable_n);
endmodule // host_port_ctrl_checker

bind host_port_ctrl host_port_ctrl_checker #(.HALF_CYC(HALF_CYC), .STROBE_MIN(STROBE_MIN),
	.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.clk(clk), .resetn(resetn),
	.host_side_clock(host_side_clock), .ctrl_addr_in(ctrl_addr_in),
	.ctrl_data_bus_oe_n(ctrl_data_bus_oe_n), .host_display_select_n(host_display_select_n),
	.host_upper_byte_enable_n(host_upper_byte_enable_n),
	.lower_write_strobe_n(lower_write_strobe_n), .read_strobe_n(read_strobe_n),
	.device_wait_n(device_wait_n), .device_reset_n(device_reset_n),
	.bus_select_strap0(bus_select_strap0), .bus_select_strap1(bus_select_strap1),
	.bus_select_strap2(bus_select_strap2), .bus_status_strap(bus_status_strap),
	.rw_dir_tie(rw_dir_tie), .endian_strap(endian_strap));

`default_nettype wire

// *** dv/display_device_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module display_device_model (
	// pacing
	input wire logic        clk,
	input wire logic [31:0] wait_len,
	// host bus
	input wire logic [16:0] ctrl_addr_in,
	input wire logic [15:0] host_data,
	input wire logic        host_data_oe_n,
	input wire logic        select_n,
	input wire logic        upper_byte_strobe_n,
	input wire logic        lower_write_strobe_n,
	input wire logic        read_strobe_n,
	output var logic [15:0] bus_level,
	output var logic        device_wait_n,
	// reset and straps
	input wire logic        device_reset_n,
	input wire logic [3:0]  bus_straps,
	input wire logic        endian_strap,
	output var logic        latched_endian,
	output var logic        latched_generic
);
	logic [15:0] mem [0:255];
	logic [15:0] last_ff = 16'h5a5a;
	int          cnt_ff = 0;
	logic        active;
	logic [7:0]  idx;

	// only the low address bits are backed, the rest of the window aliases
	assign idx = ctrl_addr_in[8:1];
	// strobes are watched on the bench clock, never on the bus clock
	assign active = !select_n && (!read_strobe_n || !lower_write_strobe_n);
	assign device_wait_n = !(active && cnt_ff < wait_len);

	// direction tie is not an input: it plays no part in transfers
	always_ff @(posedge device_reset_n) begin
		latched_endian <= endian_strap;
		latched_generic <= &bus_straps;
	end
	// released lines show the inverse of the last level, not a stale value
	always_comb begin
		if (!host_data_oe_n)
			bus_level = host_data;
		else if (!select_n && !read_strobe_n)
			bus_level = mem[idx];
		else
			bus_level = ~last_ff;
	end
	always_ff @(posedge clk) begin
		last_ff <= bus_level;
		cnt_ff <= active ? cnt_ff + 1 : 0;
		if (active && !lower_write_strobe_n && device_wait_n && latched_generic) begin
			if (upper_byte_strobe_n)
				mem[idx][7:0] <= bus_level[7:0];
			else
				mem[idx] <= bus_level;
		end
	end
endmodule // display_device_model

`default_nettype wire

// *** dv/host_port_ctrl_tb_top.sv ***
`timescale 1ns/1ns
`include "host_port_defines.svh"
`default_nettype none

module host_port_ctrl_tb_top;
	logic        clk, resetn, avs_read, avs_write, avs_waitrequest, bclk, oe_n, sel_n;
	logic        ube_n, wr_n, rd_n, wait_n, dev_rst_n, s0, s1, s2, bs, rw, endian;
	logic        lat_endian, lat_generic;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd_val;
	logic [16:0] addr;
	logic [15:0] data_i, data_o, wd;
	int          wait_len, err_count, comparisons;

	host_port_ctrl #(.TIMEOUT_CYC(64)) i_dut (.clk(clk), .resetn(resetn), .ce(1'b1),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .host_side_clock(bclk), .ctrl_addr_in(addr),
		.ctrl_data_bus_i(data_i), .ctrl_data_bus_o(data_o), .ctrl_data_bus_oe_n(oe_n),
		.host_display_select_n(sel_n), .host_upper_byte_enable_n(ube_n),
		.lower_write_strobe_n(wr_n), .read_strobe_n(rd_n), .device_wait_n(wait_n),
		.device_reset_n(dev_rst_n), .bus_select_strap0(s0), .bus_select_strap1(s1),
		.bus_select_strap2(s2), .bus_status_strap(bs), .rw_dir_tie(rw), .endian_strap(endian));
	display_device_model i_dev (.clk(clk), .wait_len(wait_len), .ctrl_addr_in(addr),
		.host_data(data_o), .host_data_oe_n(oe_n), .select_n(sel_n),
		.upper_byte_strobe_n(ube_n), .lower_write_strobe_n(wr_n), .read_strobe_n(rd_n),
		.bus_level(data_i), .device_wait_n(wait_n), .device_reset_n(dev_rst_n),
		.bus_straps({s2, s1, s0, bs}), .endian_strap(endian), .latched_endian(lat_endian),
		.latched_generic(lat_generic));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one avalon access; held until waitrequest is sampled low
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			final_report();
		end
		rd_val = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp,
		input logic [31:0] mask);
		bus(1'b1, a, 32'h0);
		check(what, rd_val & mask, exp);
	endtask

	// start a cycle, poll until idle, check and clear the sticky flags
	task automatic go(input logic [31:0] ctrl, input logic [31:0] exp_st);
		bus(1'b0, `OFS_CTRL, ctrl);
		for (int i = 0; i < 300; i++) begin
			bus(1'b1, `OFS_STATUS, 32'h0);
			if (rd_val[`ST_BUSY] === 1'b0)
				break;
		end
		if (rd_val[`ST_BUSY] !== 1'b0) begin
			err_count++;
			final_report();
		end
		check("status", rd_val & 32'h1f, exp_st);
		bus(1'b0, `OFS_STATUS, 32'h1e);
	endtask

	initial begin
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		wait_len = 0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd_chk("ctrl reset", `OFS_CTRL, 32'(`CTRL_RST), 32'hff);
		rd_chk("device held", `OFS_STATUS, 32'h100, 32'h100);
		check("straps", 32'({s2, s1, s0, bs, rw}), 32'h1f);
		$display("test reset done");
		bus(1'b0, `OFS_PINMODE, 32'h81);
		bus(1'b0, `OFS_GPIOMODE, 32'h310);
		bus(1'b0, `OFS_CTRL, 32'h18);
		bus(1'b0, `OFS_CTRL, 32'h08);
		// device reset rises one edge after the control write lands
		repeat (2) @(posedge clk);
		check("endian latch", 32'(lat_endian), 32'h1);
		check("generic latch", 32'(lat_generic), 32'h1);
		rd_chk("route endian", `OFS_STATUS, 32'h0c0, 32'h1e0);
		$display("test config done");
		bus(1'b0, `OFS_ADDR, 32'h133d_fffe);
		go(32'h09, 32'h08);
		bus(1'b0, `OFS_ADDR, 32'h1340_0000);
		go(32'h09, 32'h08);
		// in-window address, so only the routing miss is reported
		bus(1'b0, `OFS_ADDR, 32'h133e_0000);
		bus(1'b0, `OFS_PINMODE, 32'h01);
		go(32'h09, 32'h10);
		bus(1'b0, `OFS_PINMODE, 32'h81);
		$display("test refusal done");
		for (int w = 0; w <= 25; w += 25) begin
			wait_len <= w;
			wd = 16'ha55a ^ 16'(w);
			bus(1'b0, `OFS_ADDR, 32'h133f_fffe);
			bus(1'b0, `OFS_WDATA, 32'(wd));
			go(32'h09, 32'h02);
			check("device word", 32'(i_dev.mem[8'hff]), 32'(wd));
			go(32'h0b, 32'h02);
			rd_chk("read word", `OFS_RDATA, 32'(wd), 32'hffff);
			bus(1'b0, `OFS_WDATA, 32'h12c3);
			go(32'h0d, 32'h02);
			go(32'h0f, 32'h02);
			rd_chk("read byte", `OFS_RDATA, 32'hc3, 32'hff);
			go(32'h0b, 32'h02);
			rd_chk("merged word", `OFS_RDATA, 32'({wd[15:8], 8'hc3}), 32'hffff);
			$display("test transfer wait %0d done", w);
		end
		final_report();
	end
endmodule // host_port_ctrl_tb_top

`default_nettype wire
